/* File: shared/dib_pkg.sv */
// Constants, types and debounce table for the digital input debounce counter
// Operation
// - Threshold DAC is seven bits; reference chosen between high supply and precision reference.
// - Supply mode threshold equals high supply times (code minus 48) over 50.
// - Reference mode threshold equals reference times (code minus 38) over 5.
// - Short detect enable adds about 4mA sink and flags a short beyond it.
// - Open or short fault sets its alert status flag and drives alert low.
// - Input state bit is the debounced signal, inverted when invert is set.
// - A 32-bit counter counts debounced edges while digital input mode is active.
// - Counted edge polarity is rising, or falling when the inverter is enabled.
// - Low sixteen count bits in one register, upper sixteen in another.
// - Edge counter clears to zero on device reset.
// - Counter wraps from all ones to zero without any error.
// - With count enable cleared the counter holds and ignores edges.
// - Comparator watches buffered sense input, or unbuffered output node when selected.
// - Comparator output is sampled at a regular interval into the debouncer.
// - Five-bit debounce code; code 0x00 passes samples straight through.
// - One debounce mode bit selects between two debounce modes.
// - Mode zero counts toward target on differing samples, back on matching ones.
// - Mode one counts differing samples and resets on any matching sample.
// - Sample period is about 800ns; targets are counts of that period.
// - Debounce mode resets to mode zero.
package dib_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SAMPLE_PERIOD_NS = 800;
  localparam int SAMPLE_DIV_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [6:0] SAMPLE_DIV_LAST = 7'(SAMPLE_DIV_CYCLES - 1);

  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_A = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_CONFIG_B = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_STATE = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_COUNT_LOW = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_COUNT_HIGH = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_ALERT = 5'h14;

  localparam int STATE_BIT_INPUT = 0;
  localparam int STATE_BIT_RAW = 1;
  localparam int ALERT_BIT_OPEN = 0;
  localparam int ALERT_BIT_SHORT = 1;

  localparam int TARGET_W = 17;

  // input_config_a, bit 0 upward: debounce time, mode, invert, count enable,
  // sink code, sink range, open detect, short detect
  typedef struct packed {
    logic short_detect_enable;
    logic open_detect_enable;
    logic sink_range;
    logic [4:0] sink_code;
    logic count_enable;
    logic input_invert_enable;
    logic debounce_mode;
    logic [4:0] debounce_time;
  } dib_cfg_a_t;

  // input_config_b: threshold code, reference select, input select
  typedef struct packed {
    logic [6:0] reserved;
    logic input_select;
    logic threshold_reference_select;
    logic [6:0] threshold_code;
  } dib_cfg_b_t;

  // Controls handed to the analog front end
  typedef struct packed {
    logic [6:0] threshold_code;
    logic threshold_reference_select;
    logic input_select;
    logic sink_range;
    logic [4:0] sink_code;
    logic short_sink_enable;
  } dib_analog_t;

  localparam dib_cfg_a_t CFG_A_RESET = 16'h0000;
  localparam dib_cfg_b_t CFG_B_RESET = 16'h0000;
  localparam logic [15:0] CFG_B_WRITE_MASK = 16'h01FF;

  // Debounce times as counts of the 800ns sample period, rounded to nearest
  function automatic logic [TARGET_W-1:0] dib_target(input logic [4:0] code);
    logic [TARGET_W-1:0] t;
    case (code)
      5'h01: t = 17'h00010;
      5'h02: t = 17'h00017;
      5'h03: t = 17'h0001F;
      5'h04: t = 17'h00029;
      5'h05: t = 17'h00035;
      5'h06: t = 17'h00046;
      5'h07: t = 17'h0005F;
      5'h08: t = 17'h0007E;
      5'h09: t = 17'h000A3;
      5'h0A: t = 17'h000E2;
      5'h0B: t = 17'h0012D;
      5'h0C: t = 17'h00190;
      5'h0D: t = 17'h0020D;
      5'h0E: t = 17'h002BC;
      5'h0F: t = 17'h003AA;
      5'h10: t = 17'h004E3;
      5'h11: t = 17'h0065A;
      5'h12: t = 17'h008CB;
      5'h13: t = 17'h00BB9;
      5'h14: t = 17'h00FA1;
      5'h15: t = 17'h01483;
      5'h16: t = 17'h01B59;
      5'h17: t = 17'h024A0;
      5'h18: t = 17'h030D5;
      5'h19: t = 17'h03F7B;
      5'h1A: t = 17'h057E5;
      5'h1B: t = 17'h07531;
      5'h1C: t = 17'h09C41;
      5'h1D: t = 17'h0CD15;
      5'h1E: t = 17'h11170;
      5'h1F: t = 17'h16E36;
      default: t = 17'h00001;
    endcase
    return t;
  endfunction

endpackage

/* File: hdl/dib_debounce.sv */
// Two-mode sample debouncer with bypass
`timescale 1ns/1ps
module dib_debounce
  import dib_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Samples
  input wire logic sample_en,
  input wire logic sample_in,
  // Settings
  input wire logic mode,
  input wire logic [4:0] time_code,
  // Result
  output logic state_o
);

  logic [TARGET_W-1:0] cnt_reg;
  logic [TARGET_W-1:0] cnt_next;
  logic state_reg;
  logic state_next;
  logic [TARGET_W-1:0] target;
  logic bypass;

  assign target = dib_target(time_code);
  assign bypass = (time_code == 5'h00);
  assign state_o = state_reg;

  always_comb begin
    cnt_next = cnt_reg;
    state_next = state_reg;
    if (sample_en) begin
      if (bypass) begin
        state_next = sample_in;
        cnt_next = '0;
      end else if (sample_in != state_reg) begin
        // Compare with >= so a shortened target takes effect at once
        if (cnt_reg + 17'h00001 >= target) begin
          state_next = sample_in;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 17'h00001;
        end
      end else if (mode) begin
        cnt_next = '0;
      end else if (cnt_reg != '0) begin
        cnt_next = cnt_reg - 17'h00001;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      state_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      state_reg <= state_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_bypass_follow: assert property (sample_en && bypass |=> state_reg == $past(sample_in))
    else $error("bypass did not pass the sample through");
  a_mode_one_clear: assert property (sample_en && !bypass && mode
    && sample_in == state_reg |=> cnt_reg == '0 && $stable(state_reg))
    else $error("mode one did not clear on a matching sample");
  a_mode_zero_back: assert property (sample_en && !bypass && !mode
    && sample_in == state_reg && cnt_reg != '0 |=> cnt_reg == $past(cnt_reg) - 17'h00001)
    else $error("mode zero did not step back on a matching sample");
  a_state_needs_sample: assert property (!sample_en |=> $stable(state_reg))
    else $error("debounced state moved without a sample");
  c_mode_zero_flip: cover property (!mode && !bypass && sample_en ##1 $changed(state_reg));
endmodule

/* File: hdl/dib_top.sv */
// Per-channel digital input conditioning with Avalon-MM register slave
//
// Design decisions made here: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module dib_top
  import dib_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Analog front end
  input wire logic comparator_out,
  input wire logic open_fault,
  input wire logic short_fault,
  input wire logic input_mode_active,
  output dib_analog_t analog_ctrl,
  // Status pins
  output logic input_state,
  output logic alert_n
);

  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  dib_cfg_a_t cfg_a_reg;
  dib_cfg_a_t cfg_a_next;
  dib_cfg_b_t cfg_b_reg;
  dib_cfg_b_t cfg_b_next;
  logic [6:0] div_reg;
  logic [6:0] div_next;
  logic sample_en_reg;
  logic sample_en_next;
  logic deb_state;
  logic deb_prev_reg;
  logic deb_prev_next;
  logic state_reg;
  logic state_next;
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [1:0] alert_reg;
  logic [1:0] alert_next;
  logic alert_n_reg;
  logic alert_n_next;
  dib_analog_t analog_reg;
  dib_analog_t analog_next;
  logic wr_take;
  logic rd_take;
  logic qual_edge;
  logic [15:0] wmask;

  // Bus slave: every access answers on the second edge, so waitrequest is a register
  assign wr_take = avs_write && !wait_reg;
  assign rd_take = avs_read && wait_reg;
  assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb begin
    wait_next = 1'b1;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
    end
    rdata_next = rdata_reg;
    if (rd_take) begin
      case (avs_address)
        OFF_CONFIG_A: rdata_next = {16'h0000, cfg_a_reg};
        OFF_CONFIG_B: rdata_next = {16'h0000, cfg_b_reg};
        OFF_STATE: rdata_next = {30'h00000000, comparator_out, state_reg};
        OFF_COUNT_LOW: rdata_next = {16'h0000, count_reg[15:0]};
        OFF_COUNT_HIGH: rdata_next = {16'h0000, count_reg[31:16]};
        OFF_ALERT: rdata_next = {30'h00000000, alert_reg};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // Configuration registers; reserved bits never store
  always_comb begin
    cfg_a_next = cfg_a_reg;
    cfg_b_next = cfg_b_reg;
    if (wr_take && avs_address == OFF_CONFIG_A) begin
      cfg_a_next = (cfg_a_reg & ~wmask) | (avs_writedata[15:0] & wmask);
    end
    if (wr_take && avs_address == OFF_CONFIG_B) begin
      cfg_b_next = ((cfg_b_reg & ~wmask) | (avs_writedata[15:0] & wmask))
        & CFG_B_WRITE_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_a_reg <= CFG_A_RESET;
      cfg_b_reg <= CFG_B_RESET;
    end else begin
      cfg_a_reg <= cfg_a_next;
      cfg_b_reg <= cfg_b_next;
    end
  end

  // Analog controls; the DAC and sink arithmetic live in the analog domain
  always_comb begin
    analog_next.threshold_code = cfg_b_reg.threshold_code;
    analog_next.threshold_reference_select = cfg_b_reg.threshold_reference_select;
    analog_next.input_select = cfg_b_reg.input_select;
    analog_next.sink_range = cfg_a_reg.sink_range;
    analog_next.sink_code = cfg_a_reg.sink_code;
    analog_next.short_sink_enable = cfg_a_reg.short_detect_enable;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      analog_reg <= '0;
    end else begin
      analog_reg <= analog_next;
    end
  end

  // Sample divider: one enable pulse each 800ns
  always_comb begin
    if (div_reg == SAMPLE_DIV_LAST) begin
      div_next = 7'h00;
      sample_en_next = 1'b1;
    end else begin
      div_next = div_reg + 7'h01;
      sample_en_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_reg <= 7'h00;
      sample_en_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      sample_en_reg <= sample_en_next;
    end
  end

  dib_debounce u_debounce (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sample_en(sample_en_reg),
    .sample_in(comparator_out),
    .mode(cfg_a_reg.debounce_mode),
    .time_code(cfg_a_reg.debounce_time),
    .state_o(deb_state)
  );

  // Edges come from the debounced state, so a toggle of the invert bit alone
  // is never counted
  assign qual_edge = (deb_state != deb_prev_reg)
    && (deb_state != cfg_a_reg.input_invert_enable);

  always_comb begin
    deb_prev_next = deb_state;
    state_next = deb_state ^ cfg_a_reg.input_invert_enable;
    count_next = count_reg;
    if (qual_edge && cfg_a_reg.count_enable && input_mode_active) begin
      count_next = count_reg + 32'h00000001;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      deb_prev_reg <= 1'b0;
      state_reg <= 1'b0;
      count_reg <= 32'h00000000;
    end else begin
      deb_prev_reg <= deb_prev_next;
      state_reg <= state_next;
      count_reg <= count_next;
    end
  end

  // Alert flags: write one to clear, a fault in the same cycle wins
  always_comb begin
    alert_next = alert_reg;
    if (wr_take && avs_address == OFF_ALERT && avs_byteenable[0]) begin
      alert_next = alert_reg & ~avs_writedata[1:0];
    end
    if (open_fault && cfg_a_reg.open_detect_enable) begin
      alert_next[ALERT_BIT_OPEN] = 1'b1;
    end
    if (short_fault && cfg_a_reg.short_detect_enable) begin
      alert_next[ALERT_BIT_SHORT] = 1'b1;
    end
    alert_n_next = ~|alert_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_reg <= 2'b00;
      alert_n_reg <= 1'b1;
    end else begin
      alert_reg <= alert_next;
      alert_n_reg <= alert_n_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign analog_ctrl = analog_reg;
  assign input_state = state_reg;
  assign alert_n = alert_n_reg;

  // Gap counter for checks only, kept apart from the divider so a slip shows
  logic [7:0] gap_reg;
  logic [7:0] gap_next;
  logic count_on;

  assign count_on = cfg_a_reg.count_enable && input_mode_active;

  always_comb begin
    gap_next = gap_reg + 8'h01;
    if (sample_en_reg) begin
      gap_next = 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= 8'h00;
    end else begin
      gap_reg <= gap_next;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not on the second edge");
  a_open_alert_pin: assert property (open_fault && cfg_a_reg.open_detect_enable
    |=> alert_reg[ALERT_BIT_OPEN] ##1 !alert_n)
    else $error("open fault did not reach the alert pin");
  a_short_alert_flag: assert property (short_fault && cfg_a_reg.short_detect_enable
    |=> alert_reg[ALERT_BIT_SHORT])
    else $error("short fault flag not set");
  a_state_invert: assert property (##1 input_state
    == ($past(deb_state) ^ $past(cfg_a_reg.input_invert_enable)))
    else $error("input state does not match debounced value");
  a_count_one_step: assert property ($changed(count_reg)
    |-> count_reg == $past(count_reg) + 32'h00000001 && $past(qual_edge))
    else $error("edge counter moved by other than one edge");
  a_count_hold: assert property (!cfg_a_reg.count_enable |=> $stable(count_reg))
    else $error("edge counter moved while disabled");
  a_count_wrap: assert property (count_reg == 32'hFFFFFFFF && qual_edge
    && cfg_a_reg.count_enable && input_mode_active |=> count_reg == 32'h00000000)
    else $error("edge counter did not wrap to zero");
  a_count_mode_gate: assert property (!input_mode_active |=> $stable(count_reg))
    else $error("edge counter moved outside input mode");
  a_sample_spacing: assert property (sample_en_reg |=> !sample_en_reg [*8])
    else $error("sample enable pulses too close");
  a_high_half_read: assert property (rd_take && avs_address == OFF_COUNT_HIGH
    |=> avs_readdata[15:0] == $past(count_reg[31:16]))
    else $error("upper count half read wrong");
  a_low_half_read: assert property (rd_take && avs_address == OFF_COUNT_LOW
    |=> avs_readdata[15:0] == $past(count_reg[15:0]))
    else $error("lower count half read wrong");
  a_state_read: assert property (rd_take && avs_address == OFF_STATE
    |=> avs_readdata[0] == $past(state_reg))
    else $error("input state read wrong");
  a_raw_read: assert property (rd_take && avs_address == OFF_STATE
    |=> avs_readdata[1] == $past(comparator_out))
    else $error("raw comparator read wrong");
  a_readdata_hold: assert property (!rd_take |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_cfg_a_write: assert property (wr_take && avs_address == OFF_CONFIG_A
    && avs_byteenable[1:0] == 2'h3 |=> cfg_a_reg == $past(avs_writedata[15:0]))
    else $error("config a write lost");
  a_cfg_b_reserved: assert property (cfg_b_reg.reserved == 7'h00)
    else $error("reserved config bits stored");

  a_sample_gap: assert property (sample_en_reg |-> gap_reg == 8'(SAMPLE_DIV_CYCLES))
    else $error("sample period wrong");
  a_sample_at_wrap: assert property (div_reg == SAMPLE_DIV_LAST |=> sample_en_reg)
    else $error("divider wrap gave no sample");
  a_div_range: assert property (div_reg <= SAMPLE_DIV_LAST)
    else $error("divider out of range");

  a_rise_counted: assert property (deb_state && !deb_prev_reg && count_on
    && !cfg_a_reg.input_invert_enable |=> count_reg == $past(count_reg) + 32'h00000001)
    else $error("rising edge not counted");
  a_fall_counted: assert property (!deb_state && deb_prev_reg && count_on
    && cfg_a_reg.input_invert_enable |=> count_reg == $past(count_reg) + 32'h00000001)
    else $error("falling edge not counted");
  a_wrong_edge_ignored: assert property (deb_state != deb_prev_reg
    && deb_state == cfg_a_reg.input_invert_enable |=> $stable(count_reg))
    else $error("edge of wrong polarity counted");
  a_count_needs_edge: assert property (!qual_edge |=> $stable(count_reg))
    else $error("count moved with no edge");

  a_thresh_code_out: assert property (##1 analog_ctrl.threshold_code
    == $past(cfg_b_reg.threshold_code))
    else $error("threshold code not forwarded");
  a_thresh_ref_out: assert property (##1 analog_ctrl.threshold_reference_select
    == $past(cfg_b_reg.threshold_reference_select))
    else $error("threshold reference not forwarded");
  a_input_select_out: assert property (##1 analog_ctrl.input_select
    == $past(cfg_b_reg.input_select))
    else $error("input select not forwarded");
  a_short_sink_out: assert property (##1 analog_ctrl.short_sink_enable
    == $past(cfg_a_reg.short_detect_enable))
    else $error("short sink enable not forwarded");

  a_alert_pin_level: assert property (##1 alert_n == ~|$past(alert_reg))
    else $error("alert pin disagrees with flags");
  a_open_sticky: assert property (alert_reg[ALERT_BIT_OPEN] && !wr_take
    |=> alert_reg[ALERT_BIT_OPEN])
    else $error("open flag lost");
  a_short_sticky: assert property (alert_reg[ALERT_BIT_SHORT] && !wr_take
    |=> alert_reg[ALERT_BIT_SHORT])
    else $error("short flag lost");
  a_open_gated: assert property (!cfg_a_reg.open_detect_enable
    && !alert_reg[ALERT_BIT_OPEN] |=> !alert_reg[ALERT_BIT_OPEN])
    else $error("open flag set while disabled");
  a_short_gated: assert property (!cfg_a_reg.short_detect_enable
    && !alert_reg[ALERT_BIT_SHORT] |=> !alert_reg[ALERT_BIT_SHORT])
    else $error("short flag set while disabled");
  a_open_clear: assert property (wr_take && avs_address == OFF_ALERT && !open_fault
    && avs_byteenable[0] && avs_writedata[ALERT_BIT_OPEN] |=> !alert_reg[ALERT_BIT_OPEN])
    else $error("open flag not cleared");

  c_edge_counted: cover property (qual_edge && cfg_a_reg.count_enable ##1 $changed(count_reg));
  c_alert_cleared: cover property (!alert_n ##[1:20] alert_n);
  c_inverted_state: cover property (cfg_a_reg.input_invert_enable && input_state);
  c_mode_one_used: cover property (cfg_a_reg.debounce_mode && $changed(deb_state));
endmodule

/* File: tb/dib_field_model.sv */
// Field sensor model seen through the input comparator and the diagnostics
`timescale 1ns/1ps
module dib_field_model (
  // Clock
  input wire logic ref_clk,
  // Commands from the bench
  input wire logic sense_level,
  input wire logic wire_broken,
  input wire logic wire_shorted,
  // Comparator and diagnostic outputs
  output logic comparator_out = 1'b0,
  output logic open_fault = 1'b0,
  output logic short_fault = 1'b0
);
  // Outputs move only just after an edge, since the design samples them synchronously
  always @(posedge ref_clk) begin
    comparator_out <= sense_level;
    open_fault <= wire_broken;
    short_fault <= wire_shorted;
  end
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the digital input debounce counter
`timescale 1ns/1ps
module tb;
  import dib_pkg::*;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic comparator_out;
  logic open_fault;
  logic short_fault;
  logic input_mode_active = 1'b1;
  dib_analog_t analog_ctrl;
  logic input_state;
  logic alert_n;
  logic sense_level = 1'b0;
  logic wire_broken = 1'b0;
  logic wire_shorted = 1'b0;
  int errors = 0;
  int n_checks = 0;
  logic [31:0] rd;

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  dib_top u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .comparator_out(comparator_out),
    .open_fault(open_fault), .short_fault(short_fault),
    .input_mode_active(input_mode_active), .analog_ctrl(analog_ctrl),
    .input_state(input_state), .alert_n(alert_n));

  dib_field_model u_field (.ref_clk(ref_clk), .sense_level(sense_level),
    .wire_broken(wire_broken), .wire_shorted(wire_shorted),
    .comparator_out(comparator_out), .open_fault(open_fault), .short_fault(short_fault));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // One Avalon transfer; the master never assumes a latency, only the bound cuts a hang
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= addr;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) check("bus answer", 32'h1, 32'h0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] addr, input logic [31:0] e);
    bus(1'b0, addr, 32'h0);
    check(what, rd, e);
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic level(input logic v);
    @(posedge ref_clk);
    sense_level <= v;
  endtask

  task automatic wait_state(input logic v, input int lim);
    int n;
    n = 0;
    while (input_state !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check("input_state", {31'h0, input_state}, {31'h0, v});
  endtask

  function automatic logic [31:0] cfga(input logic [4:0] t, input logic m, input logic inv,
      input logic en, input logic [7:0] hi);
    return {16'h0, hi, en, inv, m, t};
  endfunction

  task automatic t_reset();
    check("alert_n", {31'h0, alert_n}, 32'h1);
    check("analog_ctrl", 32'(analog_ctrl), 32'h0);
    for (int i = 0; i < 7; i++) begin
      rd_chk("reset read", 5'(i * 4), 32'h0);
    end
    $display("test reset done");
  endtask

  task automatic t_profile(input logic rng, input logic [4:0] code, input logic oc,
      input logic sc, input logic sel);
    dib_analog_t x;
    x = {7'h37, 1'b1, sel, rng, code, sc};
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b0, {sc, oc, rng, code}));
    // Reserved bits written as ones must read back as zero
    bus(1'b1, OFF_CONFIG_B, {16'hFFFF, 7'h7F, sel, 1'b1, 7'h37});
    clk(3);
    check("analog_ctrl", 32'(analog_ctrl), 32'(x));
    rd_chk("config_a", OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b0, {sc, oc, rng, code}));
    rd_chk("config_b", OFF_CONFIG_B, {23'h0, sel, 1'b1, 7'h37});
    $display("test profile done");
  endtask

  task automatic t_bypass();
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b1, 8'h00));
    level(1'b1);
    wait_state(1'b1, 110);
    clk(4);
    rd_chk("state", OFF_STATE, 32'h3);
    rd_chk("count low", OFF_COUNT_LOW, 32'h1);
    rd_chk("count high", OFF_COUNT_HIGH, 32'h0);
    level(1'b0);
    wait_state(1'b0, 110);
    clk(4);
    rd_chk("count low", OFF_COUNT_LOW, 32'h1);
    $display("test bypass done");
  endtask

  task automatic t_invert();
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b1, 1'b1, 8'h00));
    clk(4);
    check("input_state", {31'h0, input_state}, 32'h1);
    level(1'b1);
    wait_state(1'b0, 110);
    clk(4);
    rd_chk("count low", OFF_COUNT_LOW, 32'h1);
    level(1'b0);
    wait_state(1'b1, 110);
    clk(4);
    rd_chk("count low", OFF_COUNT_LOW, 32'h2);
    $display("test invert done");
  endtask

  task automatic pulse();
    level(1'b1);
    wait_state(1'b1, 110);
    level(1'b0);
    wait_state(1'b0, 110);
    clk(4);
  endtask

  task automatic t_hold();
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b0, 8'h00));
    pulse();
    rd_chk("count low", OFF_COUNT_LOW, 32'h2);
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b1, 8'h00));
    input_mode_active <= 1'b0;
    pulse();
    rd_chk("count low", OFF_COUNT_LOW, 32'h2);
    input_mode_active <= 1'b1;
    $display("test hold done");
  endtask

  // Code 1 is a target of 16 samples; run lengths stay at least three samples clear of it
  task automatic t_mode(input logic m, input logic [31:0] cnt);
    bus(1'b1, OFF_CONFIG_A, cfga(5'h01, m, 1'b0, 1'b1, 8'h00));
    level(1'b1);
    clk(1200);
    check("input_state", {31'h0, input_state}, 32'h0);
    level(1'b0);
    clk(200);
    level(1'b1);
    clk(1000);
    check("input_state", {31'h0, input_state}, {31'h0, ~m});
    clk(1200);
    check("input_state", {31'h0, input_state}, 32'h1);
    rd_chk("count low", OFF_COUNT_LOW, cnt);
    level(1'b0);
    clk(2000);
    check("input_state", {31'h0, input_state}, 32'h0);
    $display("test mode done");
  endtask

  task automatic t_faults();
    for (int i = 0; i < 2; i++) begin
      // Sink enabled and programmed before the diagnostics are used
      bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b0, 8'hCF));
      wire_broken <= (i == 0);
      wire_shorted <= (i == 1);
      clk(5);
      check("alert_n", {31'h0, alert_n}, 32'h0);
      wire_broken <= 1'b0;
      wire_shorted <= 1'b0;
      rd_chk("alert", OFF_ALERT, 32'(1 << i));
      bus(1'b1, OFF_ALERT, 32'(1 << i));
      clk(3);
      rd_chk("alert", OFF_ALERT, 32'h0);
      check("alert_n", {31'h0, alert_n}, 32'h1);
    end
    bus(1'b1, OFF_CONFIG_A, cfga(5'h00, 1'b0, 1'b0, 1'b0, 8'h0F));
    wire_broken <= 1'b1;
    wire_shorted <= 1'b1;
    clk(5);
    rd_chk("alert", OFF_ALERT, 32'h0);
    check("alert_n", {31'h0, alert_n}, 32'h1);
    wire_broken <= 1'b0;
    wire_shorted <= 1'b0;
    $display("test faults done");
  endtask

  task automatic t_reset_mid();
    @(posedge ref_clk);
    reset_n <= 1'b0;
    clk(3);
    reset_n <= 1'b1;
    rd_chk("count low", OFF_COUNT_LOW, 32'h0);
    rd_chk("config_a", OFF_CONFIG_A, 32'h0);
    $display("test second reset done");
  endtask

  initial begin
    clk(16);
    reset_n <= 1'b1;
    t_reset();
    t_profile(1'b0, 5'h14, 1'b0, 1'b0, 1'b0);
    t_profile(1'b1, 5'h1D, 1'b0, 1'b0, 1'b1);
    t_profile(1'b0, 5'h0F, 1'b1, 1'b1, 1'b0);
    t_bypass();
    t_invert();
    t_hold();
    t_mode(1'b0, 32'h3);
    t_mode(1'b1, 32'h4);
    t_faults();
    t_reset_mid();
    stop_test();
  end

  // Tests need well under 20000 cycles; this bound only cuts a hang
  initial begin
    #500000;
    errors++;
    $display("Error watchdog expected finish seen hang");
    stop_test();
  end
endmodule
